//--- rtl/vah_top.sv
module vah_top
    import vah_pkg::*;
#(
    parameter logic [7:0] TARGET_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR   = 8'h02,
    parameter int         VAR_DEPTH   = 256
) (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic                rx_valid,
    input  wire logic [7:0]          rx_byte,
    output logic                     rx_ready,
    output logic                     tx_valid,
    output logic      [7:0]          tx_byte,
    input  wire logic                tx_ready,
    input  wire logic                prog_valid,
    input  wire vah_cmd_t            prog_cmd,
    output logic                     prog_done,
    input  wire logic                irq_enter,
    input  wire logic [VAH_PC_W-1:0] irq_vector,
    input  wire logic                work_wr,
    input  wire vah_work_t           work_in,
    output vah_work_t                work,
    output vah_flags_t               flags,
    output logic                     in_handler,
    output logic                     busy
);

    localparam int VAR_AW = $clog2(VAR_DEPTH);

    vah_state_t            state_r,      state_nxt;
    vah_cmd_t              cur_r,        cur_nxt;
    vah_cmd_t              rx_cmd_r,     rx_cmd_nxt;
    logic                  host_r,       host_nxt;
    logic [3:0]            rx_cnt_r,     rx_cnt_nxt;
    logic [7:0]            rx_sum_r,     rx_sum_nxt;
    logic [7:0]            rx_addr_r,    rx_addr_nxt;
    logic                  rx_ready_r,   rx_ready_nxt;
    vah_work_t             work_r,       work_nxt;
    vah_work_t             saved_r,      saved_nxt;
    vah_flags_t            flags_r,      flags_nxt;
    vah_flags_t            sflags_r,     sflags_nxt;
    logic                  in_handler_r, in_handler_nxt;
    logic [VAH_DATA_W-1:0] op1_r,        op1_nxt;
    logic [7:0]            status_r,     status_nxt;
    logic                  tx_valid_r,   tx_valid_nxt;
    logic [7:0]            tx_byte_r,    tx_byte_nxt;
    logic [3:0]            tx_idx_r,     tx_idx_nxt;
    logic [7:0]            tx_sum_r,     tx_sum_nxt;
    logic                  busy_r,       busy_nxt;
    logic                  prog_done_r,  prog_done_nxt;

    logic                  mem_we;
    logic [VAR_AW-1:0]     mem_waddr;
    logic [VAH_DATA_W-1:0] mem_wdata;
    logic [VAR_AW-1:0]     mem_raddr;
    logic [VAH_DATA_W-1:0] mem_rdata;
    logic [VAH_DATA_W-1:0] alu_b;
    logic [VAH_DATA_W-1:0] alu_res;
    logic                  alu_wr;
    logic                  alu_known;
    vah_flags_t            alu_cmp;
    logic                  rx_fire;
    logic                  frame_done;
    logic                  frame_good;
    logic                  is_calc;
    logic                  exec_calc;
    logic [7:0]            next_byte;

    function automatic logic [7:0] reply_byte(input logic [3:0] idx, input logic [7:0] st,
                                              input logic [7:0] ins, input logic [7:0] sum);
        case (idx)
            VAH_RPOS_HOST:   reply_byte = HOST_ADDR;
            VAH_RPOS_TARGET: reply_byte = TARGET_ADDR;
            VAH_RPOS_STATUS: reply_byte = st;
            VAH_RPOS_INSTR:  reply_byte = ins;
            VAH_RPOS_SUM:    reply_byte = sum;
            default:         reply_byte = VAH_BYTE_RST;
        endcase
    endfunction

    vah_var_mem #(
        .WIDTH (VAH_DATA_W),
        .DEPTH (VAR_DEPTH)
    ) u_mem (
        .sys_clk (sys_clk),
        .we      (mem_we),
        .waddr   (mem_waddr),
        .wdata   (mem_wdata),
        .raddr   (mem_raddr),
        .rdata   (mem_rdata)
    );

    vah_alu #(
        .W (VAH_DATA_W)
    ) u_alu (
        .op    (cur_r.typ),
        .a     (op1_r),
        .b     (alu_b),
        .res   (alu_res),
        .wr    (alu_wr),
        .known (alu_known),
        .cmp   (alu_cmp)
    );

    assign rx_fire    = rx_valid && rx_ready_r;
    assign frame_done = rx_fire && (rx_cnt_r == VAH_POS_SUM);
    assign frame_good = frame_done && (rx_byte == rx_sum_r) && (rx_addr_r == TARGET_ADDR);
    assign is_calc    = (cur_r.instr == VAH_INS_VV) || (cur_r.instr == VAH_INS_VA);
    assign exec_calc  = (state_r == S_EXEC) && is_calc && alu_known;
    assign alu_b      = (cur_r.instr == VAH_INS_VV) ? mem_rdata : work_r.acc;
    assign next_byte  = reply_byte(tx_idx_r + 4'h1, status_r, cur_r.instr, tx_sum_r);

    // Frame receiver: collects nine bytes and keeps a running byte sum.
    always_comb begin
        rx_cnt_nxt   = rx_cnt_r;
        rx_sum_nxt   = rx_sum_r;
        rx_addr_nxt  = rx_addr_r;
        rx_cmd_nxt   = rx_cmd_r;
        rx_ready_nxt = (state_nxt == S_IDLE);
        if (rx_fire) begin
            rx_sum_nxt = vah_sum(rx_sum_r, rx_byte);
            rx_cnt_nxt = rx_cnt_r + 4'h1;
            if (rx_cnt_r == VAH_POS_ADDR) begin
                rx_addr_nxt = rx_byte;
            end else if (rx_cnt_r == VAH_POS_INSTR) begin
                rx_cmd_nxt.instr = rx_byte;
            end else if (rx_cnt_r == VAH_POS_TYPE) begin
                rx_cmd_nxt.typ = rx_byte;
            end else if (rx_cnt_r == VAH_POS_BANK) begin
                rx_cmd_nxt.bank = rx_byte;
            end else if (rx_cnt_r != VAH_POS_SUM) begin
                rx_cmd_nxt.value = {rx_cmd_r.value[VAH_DATA_W-9:0], rx_byte};
            end else begin
                rx_cnt_nxt = VAH_POS_ADDR;
                rx_sum_nxt = VAH_BYTE_RST;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rx_cnt_r   <= VAH_POS_ADDR;
            rx_sum_r   <= VAH_BYTE_RST;
            rx_addr_r  <= VAH_BYTE_RST;
            rx_cmd_r   <= VAH_CMD_RST;
            rx_ready_r <= 1'b0;
        end else begin
            rx_cnt_r   <= rx_cnt_nxt;
            rx_sum_r   <= rx_sum_nxt;
            rx_addr_r  <= rx_addr_nxt;
            rx_cmd_r   <= rx_cmd_nxt;
            rx_ready_r <= rx_ready_nxt;
        end
    end

    // Execution engine and reply transmitter.
    always_comb begin
        state_nxt      = state_r;
        cur_nxt        = cur_r;
        host_nxt       = host_r;
        work_nxt       = work_r;
        saved_nxt      = saved_r;
        flags_nxt      = flags_r;
        sflags_nxt     = sflags_r;
        in_handler_nxt = in_handler_r;
        op1_nxt        = op1_r;
        status_nxt     = status_r;
        tx_valid_nxt   = tx_valid_r;
        tx_byte_nxt    = tx_byte_r;
        tx_idx_nxt     = tx_idx_r;
        tx_sum_nxt     = tx_sum_r;
        prog_done_nxt  = 1'b0;
        mem_we         = 1'b0;
        mem_waddr      = cur_r.bank[VAR_AW-1:0];
        mem_wdata      = alu_res;
        mem_raddr      = cur_r.bank[VAR_AW-1:0];
        if (work_wr) begin
            work_nxt = work_in;
        end
        case (state_r)
            S_IDLE: begin
                if (frame_good) begin
                    cur_nxt   = rx_cmd_r;
                    host_nxt  = 1'b1;
                    state_nxt = S_RD1;
                end else if (irq_enter && !in_handler_r) begin
                    saved_nxt      = work_r;
                    sflags_nxt     = flags_r;
                    work_nxt.pc    = irq_vector;
                    in_handler_nxt = 1'b1;
                end else if (prog_valid && !frame_done && !prog_done_r) begin
                    cur_nxt   = prog_cmd;
                    host_nxt  = 1'b0;
                    state_nxt = S_RD1;
                end
            end
            S_RD1: begin
                mem_raddr = cur_r.bank[VAR_AW-1:0];
                state_nxt = S_RD2;
            end
            S_RD2: begin
                op1_nxt   = mem_rdata;
                mem_raddr = cur_r.value[VAR_AW-1:0];
                state_nxt = S_EXEC;
            end
            S_EXEC: begin
                status_nxt    = VAH_ST_OK;
                state_nxt     = host_r ? S_REPLY : S_IDLE;
                prog_done_nxt = !host_r;
                if (cur_r.instr == VAH_INS_RETURN) begin
                    if (in_handler_r) begin
                        work_nxt       = saved_r;
                        flags_nxt      = sflags_r;
                        in_handler_nxt = 1'b0;
                    end
                end else if (exec_calc) begin
                    mem_we = alu_wr;
                    if (cur_r.typ == VAH_OP_COMP) begin
                        flags_nxt = alu_cmp;
                    end
                    if (cur_r.typ == VAH_OP_SWAP) begin
                        if (cur_r.instr == VAH_INS_VV) begin
                            state_nxt     = S_WR2;
                            prog_done_nxt = 1'b0;
                        end else begin
                            work_nxt.acc = op1_r;
                        end
                    end
                end else begin
                    status_nxt = is_calc ? VAH_ST_BAD_TYPE : VAH_ST_BAD_CMD;
                end
            end
            S_WR2: begin
                mem_we        = 1'b1;
                mem_waddr     = cur_r.value[VAR_AW-1:0];
                mem_wdata     = op1_r;
                state_nxt     = host_r ? S_REPLY : S_IDLE;
                prog_done_nxt = !host_r;
            end
            S_REPLY: begin
                if (tx_valid_r && tx_ready) begin
                    if (tx_idx_r == VAH_RPOS_SUM) begin
                        tx_valid_nxt = 1'b0;
                        state_nxt    = S_IDLE;
                    end else begin
                        tx_idx_nxt  = tx_idx_r + 4'h1;
                        tx_byte_nxt = next_byte;
                        tx_sum_nxt  = vah_sum(tx_sum_r, next_byte);
                    end
                end
            end
            default: state_nxt = S_IDLE;
        endcase
        if ((state_nxt == S_REPLY) && (state_r != S_REPLY)) begin
            tx_valid_nxt = 1'b1;
            tx_idx_nxt   = VAH_RPOS_HOST;
            tx_byte_nxt  = HOST_ADDR;
            tx_sum_nxt   = HOST_ADDR;
        end
        busy_nxt = (state_nxt != S_IDLE);
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r      <= S_IDLE;
            cur_r        <= VAH_CMD_RST;
            host_r       <= 1'b0;
            work_r       <= VAH_WORK_RST;
            saved_r      <= VAH_WORK_RST;
            flags_r      <= VAH_FLAGS_RST;
            sflags_r     <= VAH_FLAGS_RST;
            in_handler_r <= 1'b0;
            op1_r        <= '0;
            status_r     <= VAH_ST_OK;
            tx_valid_r   <= 1'b0;
            tx_byte_r    <= VAH_BYTE_RST;
            tx_idx_r     <= VAH_RPOS_HOST;
            tx_sum_r     <= VAH_BYTE_RST;
            busy_r       <= 1'b0;
            prog_done_r  <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            cur_r        <= cur_nxt;
            host_r       <= host_nxt;
            work_r       <= work_nxt;
            saved_r      <= saved_nxt;
            flags_r      <= flags_nxt;
            sflags_r     <= sflags_nxt;
            in_handler_r <= in_handler_nxt;
            op1_r        <= op1_nxt;
            status_r     <= status_nxt;
            tx_valid_r   <= tx_valid_nxt;
            tx_byte_r    <= tx_byte_nxt;
            tx_idx_r     <= tx_idx_nxt;
            tx_sum_r     <= tx_sum_nxt;
            busy_r       <= busy_nxt;
            prog_done_r  <= prog_done_nxt;
        end
    end

    assign rx_ready   = rx_ready_r;
    assign tx_valid   = tx_valid_r;
    assign tx_byte    = tx_byte_r;
    assign prog_done  = prog_done_r;
    assign work       = work_r;
    assign flags      = flags_r;
    assign in_handler = in_handler_r;
    assign busy       = busy_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_exec_return;
        (state_r == S_EXEC) && (cur_r.instr == VAH_INS_RETURN) && in_handler_r;
    endsequence

    sequence s_take;
        (state_r == S_IDLE) && (state_nxt == S_RD1);
    endsequence

    a_return_restore: assert property (s_exec_return |=> (work_r.acc == $past(saved_r.acc))
        && (work_r.x == $past(saved_r.x)) && (flags_r == $past(sflags_r)))
        else $error("Return did not restore saved registers.");
    a_return_resume: assert property (s_exec_return |=> (work_r.pc == $past(saved_r.pc))
        && !in_handler_r)
        else $error("Return did not resume interrupted flow.");
    a_index_fetch: assert property (s_take |=> (mem_raddr == cur_r.bank[VAR_AW-1:0])
        ##1 (state_r == S_RD2) && (mem_raddr == cur_r.value[VAR_AW-1:0]))
        else $error("Variable indices not taken from bank and value.");
    a_vv_keep_acc: assert property ((state_r == S_EXEC) && (cur_r.instr == VAH_INS_VV)
        && !work_wr |=> (work_r.acc == $past(work_r.acc)) && (work_r.x == $past(work_r.x)))
        else $error("Two-variable command changed accumulator or X.");
    a_vv_dest: assert property ((state_r == S_EXEC) && mem_we |->
        mem_waddr == cur_r.bank[VAR_AW-1:0])
        else $error("Result not written to first variable.");
    a_va_operand: assert property ((state_r == S_EXEC) && (cur_r.instr == VAH_INS_VA)
        |-> alu_b == work_r.acc)
        else $error("Accumulator not used as second operand.");
    a_add_result: assert property (exec_calc && (cur_r.typ == VAH_OP_ADD) |-> mem_we
        && (mem_wdata == op1_r + alu_b))
        else $error("Add result wrong.");
    a_xor_result: assert property (exec_calc && (cur_r.typ == VAH_OP_XOR) |->
        mem_wdata == (op1_r ^ alu_b))
        else $error("Exclusive or result wrong.");
    a_not_result: assert property (exec_calc && (cur_r.typ == VAH_OP_NOT) |->
        mem_we && (mem_wdata == ~alu_b))
        else $error("Inverse result wrong.");
    a_load_result: assert property (exec_calc && (cur_r.typ == VAH_OP_LOAD) |->
        mem_we && (mem_wdata == alu_b))
        else $error("Copy result wrong.");
    a_swap_both: assert property (exec_calc && (cur_r.typ == VAH_OP_SWAP)
        && (cur_r.instr == VAH_INS_VV) |-> mem_we && (mem_wdata == alu_b) ##1 (state_r == S_WR2)
        && mem_we && (mem_wdata == op1_r) && (mem_waddr == cur_r.value[VAR_AW-1:0]))
        else $error("Swap did not update both variables.");
    a_comp_keep: assert property (exec_calc && (cur_r.typ == VAH_OP_COMP) |-> !mem_we)
        else $error("Compare altered a variable.");
    a_comp_flags: assert property (exec_calc && (cur_r.typ == VAH_OP_COMP) |=>
        (flags_r.eq == ($past(op1_r) == $past(alu_b)))
        && (flags_r.lt == ($signed($past(op1_r)) < $signed($past(alu_b)))))
        else $error("Compare flags wrong.");
    a_reply_ok: assert property (tx_valid_r && (tx_idx_r == VAH_RPOS_STATUS)
        && ((cur_r.instr == VAH_INS_RETURN) || (is_calc && (cur_r.typ <= VAH_OP_COMP)))
        |-> tx_byte_r == VAH_ST_OK)
        else $error("Reply status not OK.");
    a_reply_start: assert property ((state_r != S_REPLY) && (state_nxt == S_REPLY) |=>
        tx_valid_r && (tx_byte_r == HOST_ADDR) && (tx_idx_r == VAH_RPOS_HOST))
        else $error("Reply does not open with host address.");
    a_bad_frame: assert property (frame_done && !frame_good && (state_r == S_IDLE)
        && !prog_valid |=> state_r == S_IDLE)
        else $error("Frame with bad checksum was executed.");
    a_frame_take: assert property (frame_good && (state_r == S_IDLE) |=>
        cur_r == $past(rx_cmd_r))
        else $error("Frame fields not taken in order.");

endmodule

//--- inc/vah_pkg.sv
package vah_pkg;

    localparam int         VAH_DATA_W     = 32;
    localparam int         VAH_PC_W       = 16;

    localparam logic [7:0] VAH_INS_RETURN = 8'h26;
    localparam logic [7:0] VAH_INS_VV     = 8'h28;
    localparam logic [7:0] VAH_INS_VA     = 8'h29;

    localparam logic [7:0] VAH_ST_OK       = 8'h64;
    localparam logic [7:0] VAH_ST_BAD_CMD  = 8'h02;
    localparam logic [7:0] VAH_ST_BAD_TYPE = 8'h03;

    localparam logic [7:0] VAH_OP_ADD  = 8'h00;
    localparam logic [7:0] VAH_OP_SUB  = 8'h01;
    localparam logic [7:0] VAH_OP_MUL  = 8'h02;
    localparam logic [7:0] VAH_OP_DIV  = 8'h03;
    localparam logic [7:0] VAH_OP_MOD  = 8'h04;
    localparam logic [7:0] VAH_OP_AND  = 8'h05;
    localparam logic [7:0] VAH_OP_OR   = 8'h06;
    localparam logic [7:0] VAH_OP_XOR  = 8'h07;
    localparam logic [7:0] VAH_OP_NOT  = 8'h08;
    localparam logic [7:0] VAH_OP_LOAD = 8'h09;
    localparam logic [7:0] VAH_OP_SWAP = 8'h0A;
    localparam logic [7:0] VAH_OP_COMP = 8'h0B;

    localparam logic [3:0] VAH_POS_ADDR  = 4'h0;
    localparam logic [3:0] VAH_POS_INSTR = 4'h1;
    localparam logic [3:0] VAH_POS_TYPE  = 4'h2;
    localparam logic [3:0] VAH_POS_BANK  = 4'h3;
    localparam logic [3:0] VAH_POS_SUM   = 4'h8;

    localparam logic [3:0] VAH_RPOS_HOST   = 4'h0;
    localparam logic [3:0] VAH_RPOS_TARGET = 4'h1;
    localparam logic [3:0] VAH_RPOS_STATUS = 4'h2;
    localparam logic [3:0] VAH_RPOS_INSTR  = 4'h3;
    localparam logic [3:0] VAH_RPOS_SUM    = 4'h8;

    typedef struct packed {
        logic [7:0]            instr;
        logic [7:0]            typ;
        logic [7:0]            bank;
        logic [VAH_DATA_W-1:0] value;
    } vah_cmd_t;

    typedef struct packed {
        logic eq;
        logic lt;
        logic gt;
    } vah_flags_t;

    typedef struct packed {
        logic [VAH_DATA_W-1:0] acc;
        logic [VAH_DATA_W-1:0] x;
        logic [VAH_PC_W-1:0]   pc;
    } vah_work_t;

    typedef enum logic [2:0] {
        S_IDLE,
        S_RD1,
        S_RD2,
        S_EXEC,
        S_WR2,
        S_REPLY
    } vah_state_t;

    localparam vah_cmd_t   VAH_CMD_RST   = '0;
    localparam vah_flags_t VAH_FLAGS_RST = '0;
    localparam vah_work_t  VAH_WORK_RST  = '0;
    localparam logic [7:0] VAH_BYTE_RST  = 8'h00;

    function automatic logic [7:0] vah_sum(input logic [7:0] s, input logic [7:0] b);
        vah_sum = s + b;
    endfunction

endpackage

//--- rtl/vah_var_mem.sv
module vah_var_mem
    import vah_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 256,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             sys_clk,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    // Read data is registered; a read issued in one cycle is seen in the next.
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

//--- rtl/vah_alu.sv
module vah_alu
    import vah_pkg::*;
#(
    parameter int W = 32
) (
    input  wire logic [7:0]   op,
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic      [W-1:0] res,
    output logic              wr,
    output logic              known,
    output vah_flags_t        cmp
);

    logic [2*W-1:0] prod;

    assign prod = a * b;

    always_comb begin
        res   = b;
        wr    = 1'b1;
        known = 1'b1;
        cmp.eq = (a == b);
        cmp.lt = ($signed(a) < $signed(b));
        cmp.gt = ($signed(a) > $signed(b));
        case (op)
            VAH_OP_ADD:  res = a + b;
            VAH_OP_SUB:  res = a - b;
            VAH_OP_MUL:  res = prod[W-1:0];
            VAH_OP_DIV: begin
                wr  = (b != '0);
                res = (b != '0) ? W'($signed(a) / $signed(b)) : a;
            end
            VAH_OP_MOD: begin
                wr  = (b != '0);
                res = (b != '0) ? W'($signed(a) % $signed(b)) : a;
            end
            VAH_OP_AND:  res = a & b;
            VAH_OP_OR:   res = a | b;
            VAH_OP_XOR:  res = a ^ b;
            VAH_OP_NOT:  res = ~b;
            VAH_OP_LOAD: res = b;
            VAH_OP_SWAP: res = b;
            VAH_OP_COMP: wr = 1'b0;
            default: begin
                wr    = 1'b0;
                known = 1'b0;
            end
        endcase
    end

endmodule

//--- testbench/vah_host.sv
module vah_host (
    input  wire logic       sys_clk,
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    input  wire logic       rx_ready,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_byte,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
        tx_ready = 1'b1;
    end
    // Sends a frame with its byte sum last, then gathers the reply bytes.
    task automatic frame(input logic [7:0] f [8], input logic [7:0] bad,
                         output logic [7:0] r [9], output int n);
        logic [7:0] s;
        logic       ok;
        s = 8'h00;
        n = 0;
        @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            rx_valid <= 1'b1;
            rx_byte  <= (i < 8) ? f[i] : s + bad;
            if (i < 8) s = s + f[i];
            do begin
                @(negedge sys_clk) ok = rx_ready;
                @(posedge sys_clk);
            end while (ok !== 1'b1);
        end
        rx_valid <= 1'b0;
        rx_byte  <= ~rx_byte;
        for (int c = 0; c < 40 && n < 9; c++) begin
            @(negedge sys_clk);
            if (tx_valid === 1'b1) begin
                r[n] = tx_byte;
                n++;
            end
        end
    endtask
endmodule

//--- testbench/testbench.sv
module testbench
    import vah_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0, resetn = 1'b0, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_byte, tx_byte;
    logic prog_valid = 1'b0, prog_done, irq_enter = 1'b0, work_wr = 1'b0, in_handler, busy;
    logic [VAH_PC_W-1:0] irq_vector = 16'h0200;
    vah_cmd_t prog_cmd = VAH_CMD_RST;
    vah_work_t work_in = VAH_WORK_RST, work;
    vah_flags_t flags;
    int errors = 0, comparisons = 0, cycles = 0;
    always #25 sys_clk = ~sys_clk;
    vah_host host (.*);
    vah_top dut (.*);
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic setw(input logic [31:0] a, input logic [15:0] pc);
        @(posedge sys_clk);
        work_wr <= 1'b1;
        work_in <= '{acc: a, x: 32'h5A5A, pc: pc};
        @(posedge sys_clk);
        work_wr <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] ins, typ, bank, input logic [31:0] v,
                       input logic [7:0] bad = 8'h00, input logic [7:0] st = 8'h64);
        logic [7:0] f [8];
        logic [7:0] r [9];
        logic [7:0] s;
        int n;
        f = '{8'h01, ins, typ, bank, v[31:24], v[23:16], v[15:8], v[7:0]};
        host.frame(f, bad, r, n);
        s = 8'h00;
        for (int i = 0; i < 8; i++) s = s + r[i];
        if (bad != 0) chk("silent", 0, n);
        else begin
            chk("head", {8'h02, 8'h01, st, ins}, {r[0], r[1], r[2], r[3]});
            chk("sum", s, r[8]);
        end
    endtask
    // Swaps the accumulator, cleared first, with a variable to show it.
    task automatic peek(input logic [7:0] i, input logic [31:0] e);
        setw(0, 0);
        cmd(8'h29, 8'h0A, i, 0);
        chk("var", e, work.acc);
    endtask
    task automatic t_ops;
        logic [31:0] a, b, e [9];
        a = -20;
        b = 6;
        e = '{a + b, a - b, a * b, -3, -2, a & b, a | b, a ^ b, ~b};
        for (int op = 0; op < 9; op++) begin
            setw(a, 0);
            cmd(8'h29, 8'h09, 8'h05, 0);
            setw(b, 0);
            cmd(8'h29, op, 8'h05, 32'hFFFFFFFF);
            peek(8'h05, e[op]);
        end
    endtask
    task automatic t_vv;
        setw(11, 0);
        cmd(8'h29, 8'h09, 8'h01, 0);
        setw(4, 0);
        cmd(8'h29, 8'h09, 8'hFF, 0);
        cmd(8'h28, 8'h01, 8'h01, 32'hFF);
        chk("acc x", {32'h4, 32'h5A5A}, {work.acc, work.x});
        cmd(8'h28, 8'h0A, 8'h01, 32'hFF);
        peek(8'h01, 4);
        peek(8'hFF, 7);
    endtask
    task automatic t_bad;
        cmd(8'h29, 8'h0C, 8'h05, 0, 8'h00, 8'h03);
        cmd(8'h7F, 8'h00, 8'h05, 0, 8'h00, 8'h02);
        cmd(8'h29, 8'h09, 8'h05, 0, 8'h01);
        peek(8'h05, 0);
    endtask
    task automatic t_ret;
        setw(2, 0);
        cmd(8'h29, 8'h09, 8'h05, 0);
        cmd(8'h29, 8'h0B, 8'h05, 0);
        chk("flags eq", 3'b100, flags);
        setw(32'h1234, 16'h0033);
        @(posedge sys_clk);
        irq_enter <= 1'b1;
        @(posedge sys_clk);
        irq_enter <= 1'b0;
        @(negedge sys_clk);
        chk("enter", {1'b1, 16'h0200}, {in_handler, work.pc});
        setw(-3, 16'h0077);
        cmd(8'h29, 8'h0B, 8'h05, 0);
        chk("flags gt", 3'b001, flags);
        @(posedge sys_clk);
        prog_cmd <= '{instr: 8'h26, typ: 8'hFF, bank: 8'h00, value: 0};
        prog_valid <= 1'b1;
        for (int c = 0; c < 20 && prog_done !== 1'b1; c++) @(negedge sys_clk);
        @(posedge sys_clk);
        prog_valid <= 1'b0;
        @(negedge sys_clk);
        chk("ret", {1'b0, 32'h1234, 16'h0033, 3'b100},
            {in_handler, work.acc, work.pc, flags});
        peek(8'h05, 2);
    endtask
    task automatic test_done;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        t_ops();
        t_vv();
        t_bad();
        t_ret();
        test_done();
    end
endmodule
